//--- tlb_pkg.sv
// package for the translation buffer: sizes, register map, field layout,
// command codes, reset values and the types that travel between blocks.
// assumes a single processor clock; nothing here holds logic.

package tlb_pkg;

  // ****************************************
  // address geometry
  // ****************************************
  localparam int VA_W = 40;
  localparam int PA_W = 36;
  localparam int VPN_W = 28;
  localparam int VPN32_W = 20;
  localparam int PFN_W = 24;
  localparam int MASK_W = 12;
  localparam int DATA_W = 30;
  localparam int PAGE_SHIFT = 12;
  localparam int TAG_MAX_W = 8;
  localparam int TAG_W_FIXED = 6;
  localparam int TAG_W_VAR = 8;
  localparam int REFILL_LOW_W = 21;
  localparam int REFILL_VA_LSB = 13;
  localparam int REFILL_VA_MSB = 31;

  // ****************************************
  // register port and map
  // ****************************************
  localparam int REG_AW = 8;
  localparam int REG_DW = 64;
  localparam logic [REG_AW-1:0] REG_ENTRY_KEY = 8'h00;
  localparam logic [REG_AW-1:0] REG_DATA_EVEN = 8'h04;
  localparam logic [REG_AW-1:0] REG_DATA_ODD = 8'h08;
  localparam logic [REG_AW-1:0] REG_PAGE_MASK = 8'h0c;
  localparam logic [REG_AW-1:0] REG_ENTRY_SELECT = 8'h10;
  localparam logic [REG_AW-1:0] REG_REPLACE_CNT = 8'h14;
  localparam logic [REG_AW-1:0] REG_FAULT_ADDR = 8'h18;
  localparam logic [REG_AW-1:0] REG_REFILL_PTR = 8'h1c;
  localparam logic [REG_AW-1:0] REG_COMMAND = 8'h20;
  localparam logic [REG_AW-1:0] REG_ADDR_MODE = 8'h24;
  localparam logic [REG_AW-1:0] REG_FAULT_CAUSE = 8'h28;

  // ****************************************
  // field positions
  // ****************************************
  localparam int KEY_TAG_LSB = 0;
  localparam int KEY_VPN_LSB = 12;
  localparam int MASK_LSB = 13;
  localparam int DATA_GLOBAL_BIT = 0;
  localparam int DATA_VALID_BIT = 1;
  localparam int DATA_WRITE_BIT = 2;
  localparam int DATA_ATTR_LSB = 3;
  localparam int DATA_PFN_LSB = 6;

  // ****************************************
  // commands and attribute codes
  // ****************************************
  localparam logic [7:0] CMD_READ_INDEXED = 8'h01;
  localparam logic [7:0] CMD_WRITE_INDEXED = 8'h02;
  localparam logic [7:0] CMD_WRITE_RANDOM = 8'h04;
  localparam logic [2:0] ATTR_WT_NOALLOC = 3'h0;
  localparam logic [2:0] ATTR_WT_ALLOC = 3'h1;
  localparam logic [2:0] ATTR_UNCACHED = 3'h2;
  localparam logic [2:0] ATTR_WRITE_BACK = 3'h3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [REG_DW-1:0] RST_REG = 64'h0;
  localparam logic RST_WIDE_MODE = 1'b0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ACC_FETCH = 2'h0, ACC_LOAD = 2'h1, ACC_STORE = 2'h2} tlb_acc_t;
  typedef enum logic [1:0] {
    FLT_NONE = 2'h0, FLT_REFILL = 2'h1, FLT_INVALID = 2'h2, FLT_WRITE = 2'h3
  } tlb_fault_t;
  typedef enum logic [2:0] {
    CP_WT_NOALLOC = 3'h0, CP_WT_ALLOC = 3'h1, CP_UNCACHED = 3'h2,
    CP_WRITE_BACK = 3'h3, CP_RESERVED = 3'h4
  } tlb_cache_t;

  typedef struct packed {
    logic valid;
    tlb_acc_t kind;
    logic [VA_W-1:0] va;
  } tlb_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic fault;
    tlb_fault_t cause;
    logic [PA_W-1:0] pa;
    logic uncached;
    tlb_cache_t policy;
  } tlb_resp_t;

  typedef struct packed {
    logic [VPN_W-1:0] virtual_page_number;
    logic [TAG_MAX_W-1:0] tag;
    logic glob;
    logic [MASK_W-1:0] mask;
    logic [DATA_W-1:0] even;
    logic [DATA_W-1:0] odd;
  } tlb_entry_t;

endpackage

//--- tlb_entry_match.sv
// one comparator of the associative buffer: stored key against presented key.
// assumes the caller forces mask to zero in the fixed-page configuration.
`timescale 1ns/10ps
module tlb_entry_match #(
  parameter bit VAR_PAGE = 1'b1,
  parameter int TAG_W = 8
)(
  // stored entry
  input tlb_pkg::tlb_entry_t entry,
  // presented key
  input wire logic [tlb_pkg::VPN_W-1:0] virtual_page_number,
  input wire logic [tlb_pkg::TAG_MAX_W-1:0] tag,
  // result
  output logic hit,
  output logic oddSel
);
  import tlb_pkg::*;

  logic [VPN_W-1:0] ignore;
  logic tagOk;

  always_comb
  begin
    // in the variable-page build the low vpn bit picks the half of a pair, so it takes no part in the match
    ignore = {{(VPN_W-MASK_W-1){1'b0}}, entry.mask, VAR_PAGE};
    tagOk = entry.glob || (entry.tag[TAG_W-1:0] == tag[TAG_W-1:0]);
    hit = (((entry.virtual_page_number ^ virtual_page_number) & ~ignore) == '0) && tagOk;
    oddSel = VAR_PAGE ? virtual_page_number[0] : 1'b0;
    // half select sits just above the page offset of this entry's size
    for (int i = 0; i < MASK_W; i++)
      if (VAR_PAGE && entry.mask[i])
        oddSel = virtual_page_number[i+1];
  end

endmodule

//--- tlb_address_translation.sv
// fully associative translation buffer with its staging registers.
// assumes one processor clock, a lookup request every cycle at most and
// software that never installs two entries matching one key.
//
// Behaviour
// - fixed-page: 4 Kbyte pages, low 12 address bits pass straight through.
// - variable-page: per-entry page size 4 Kb up to 16 Mb from mask.
// - 64 single entries fixed, 16 or 48 even/odd pairs variable.
// - every entry compared with the key in parallel; matching data returned.
// - 32-bit addressing: page number 20 bits down to 8 bits.
// - 64-bit addressing: page number 28 bits down to 16 bits.
// - variable-page: stored key is page number halved; dropped bit picks even or odd half.
// - key includes address-space tag, 6 or 8 bits; other tags match only global entries.
// - global entries match on page number alone.
// - physical address is frame number glued to untranslated offset bits.
// - fixed-page: no-cache flag 1 means uncacheable, 0 cacheable.
// - variable-page: attribute 0,1 write-through, 2 uncached, 3 write-back.
// - uncached pages bypass cache lookup and refill.
// - stores need write permit; otherwise a translation trap.
// - entry marked invalid traps differently from refill.
// - no matching entry gives a refill trap.
// - any trap loads faulting address and preloads refill pointer and key.
// - entry reads and writes go through key and data staging registers.
// - entry select register picks the indexed read or write slot.
// - free-running replace counter chooses the random write slot.
// - refill pointer low 21 bits follow the fault; upper bits software.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module tlb_address_translation #(
  parameter bit VAR_PAGE = 1'b1,
  parameter int ENTRIES = 48,
  parameter bit USABLE_VAL = 1'b0
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [tlb_pkg::REG_AW-1:0] regAddr,
  input wire logic [tlb_pkg::REG_DW-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [tlb_pkg::REG_DW-1:0] regRdata,
  // pipeline request
  input tlb_pkg::tlb_req_t lookupReq,
  // translated answer towards cache and memory
  output tlb_pkg::tlb_resp_t lookupResp
);
  import tlb_pkg::*;

  // ****************************************
  // sizing
  // ****************************************
  localparam int TAG_W = VAR_PAGE ? TAG_W_VAR : TAG_W_FIXED;
  localparam int IDX_W = $clog2(ENTRIES);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(ENTRIES - 1);
  localparam logic [TAG_MAX_W-1:0] TAG_KEEP = TAG_MAX_W'((1 << TAG_W) - 1);
  localparam int OFF_W = MASK_W + PAGE_SHIFT;

  function automatic logic [VPN_W-1:0] vpn_of(input logic [VA_W-1:0] va, input logic wide);
    // 32-bit mode keeps 20 page bits, 64-bit mode 28
    vpn_of = wide ? va[VA_W-1:PAGE_SHIFT] : {{(VPN_W-VPN32_W){1'b0}}, va[31:PAGE_SHIFT]};
  endfunction

  function automatic logic [VPN_W-1:0] key_of(input logic [VPN_W-1:0] virtual_page_number);
    key_of = VAR_PAGE ? {virtual_page_number[VPN_W-1:1], 1'b0} : virtual_page_number;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [VPN_W-1:0] keyVpn, next_keyVpn;
  logic [TAG_MAX_W-1:0] keyTag, next_keyTag;
  logic [DATA_W-1:0] dataEven, next_dataEven;
  logic [DATA_W-1:0] dataOdd, next_dataOdd;
  logic [MASK_W-1:0] page_size_mask, next_page_size_mask;
  logic [IDX_W-1:0] entrySel, next_entrySel;
  logic [IDX_W-1:0] replaceCnt, next_replaceCnt;
  logic [VA_W-1:0] faultAddr, next_faultAddr;
  logic [REG_DW-1:0] refillPtr, next_refillPtr;
  logic wideMode, next_wideMode;
  tlb_fault_t lastCause, next_lastCause;
  logic [REG_DW-1:0] next_regRdata;
  tlb_resp_t next_resp;
  tlb_entry_t entries [ENTRIES];
  logic entWrite;
  logic [IDX_W-1:0] entIdx;
  tlb_entry_t entNew;

  // ****************************************
  // associative match
  // ****************************************
  logic [VPN_W-1:0] lkVpn;
  logic [ENTRIES-1:0] hitVec;
  logic [ENTRIES-1:0] oddVec;

  assign lkVpn = vpn_of(lookupReq.va, wideMode);

  for (genvar i = 0; i < ENTRIES; i++)
  begin : g_match
    tlb_entry_match #(
      .VAR_PAGE(VAR_PAGE),
      .TAG_W(TAG_W)
    ) u_match (
      .entry(entries[i]),
      .virtual_page_number(lkVpn),
      .tag(keyTag),
      .hit(hitVec[i]),
      .oddSel(oddVec[i])
    );
  end

  logic lkHit;
  logic [DATA_W-1:0] selData;
  logic [MASK_W-1:0] selMask;
  logic [PFN_W-1:0] selPfn;
  logic [2:0] selAttr;
  logic [OFF_W-1:0] offMask;
  logic [PA_W-1:0] lkPa;
  tlb_fault_t lkCause;
  logic lkUncached;
  tlb_cache_t lkPolicy;

  always_comb
  begin
    lkHit = |hitVec;
    selData = '0;
    selMask = '0;
    // highest matching index wins: overlapping entries are software's fault
    for (int i = 0; i < ENTRIES; i++)
      if (hitVec[i])
      begin
        selData = oddVec[i] ? entries[i].odd : entries[i].even;
        selMask = entries[i].mask;
      end
    selPfn = selData[DATA_PFN_LSB +: PFN_W];
    selAttr = selData[DATA_ATTR_LSB +: 3];
    offMask = {selMask, {PAGE_SHIFT{1'b1}}};
    lkPa = ({selPfn, {PAGE_SHIFT{1'b0}}} & ~PA_W'(offMask))
         | (lookupReq.va[PA_W-1:0] & PA_W'(offMask));
    if (!lkHit)
      lkCause = FLT_REFILL;
    else if (selData[DATA_VALID_BIT] != USABLE_VAL)
      lkCause = FLT_INVALID;
    else if (lookupReq.kind == ACC_STORE && !selData[DATA_WRITE_BIT])
      lkCause = FLT_WRITE;
    else
      lkCause = FLT_NONE;
    if (!VAR_PAGE)
      lkPolicy = selAttr[0] ? CP_UNCACHED : CP_WT_NOALLOC;
    else
      case (selAttr)
        ATTR_WT_NOALLOC: lkPolicy = CP_WT_NOALLOC;
        ATTR_WT_ALLOC: lkPolicy = CP_WT_ALLOC;
        ATTR_UNCACHED: lkPolicy = CP_UNCACHED;
        ATTR_WRITE_BACK: lkPolicy = CP_WRITE_BACK;
        default: lkPolicy = CP_RESERVED;
      endcase
    lkUncached = (lkPolicy == CP_UNCACHED);
    next_resp.valid = lookupReq.valid;
    next_resp.hit = lookupReq.valid && lkHit;
    next_resp.cause = lookupReq.valid ? lkCause : FLT_NONE;
    next_resp.fault = lookupReq.valid && (lkCause != FLT_NONE);
    next_resp.pa = (lookupReq.valid && lkHit) ? lkPa : '0;
    next_resp.uncached = lookupReq.valid && lkHit && lkUncached;
    next_resp.policy = lkPolicy;
  end

  // ****************************************
  // staging registers and commands
  // ****************************************
  always_comb
  begin
    next_keyVpn = keyVpn;
    next_keyTag = keyTag;
    next_dataEven = dataEven;
    next_dataOdd = dataOdd;
    next_page_size_mask = page_size_mask;
    next_entrySel = entrySel;
    next_faultAddr = faultAddr;
    next_refillPtr = refillPtr;
    next_wideMode = wideMode;
    next_lastCause = lastCause;
    next_replaceCnt = (replaceCnt == '0) ? LAST_IDX : replaceCnt - 1'b1;
    entWrite = 1'b0;
    entIdx = entrySel;
    entNew.virtual_page_number = keyVpn;
    entNew.tag = keyTag;
    entNew.glob = VAR_PAGE ? (dataEven[DATA_GLOBAL_BIT] & dataOdd[DATA_GLOBAL_BIT])
                           : dataEven[DATA_GLOBAL_BIT];
    entNew.mask = VAR_PAGE ? page_size_mask : '0;
    entNew.even = dataEven;
    entNew.odd = VAR_PAGE ? dataOdd : '0;
    next_regRdata = '0;
    if (regRead)
      case (regAddr)
        REG_ENTRY_KEY: next_regRdata = {{(REG_DW-VPN_W-KEY_VPN_LSB){1'b0}}, keyVpn,
                                        {(KEY_VPN_LSB-TAG_MAX_W){1'b0}}, keyTag};
        REG_DATA_EVEN: next_regRdata = REG_DW'(dataEven);
        REG_DATA_ODD: next_regRdata = REG_DW'(dataOdd);
        REG_PAGE_MASK: next_regRdata = REG_DW'(page_size_mask) << MASK_LSB;
        REG_ENTRY_SELECT: next_regRdata = REG_DW'(entrySel);
        REG_REPLACE_CNT: next_regRdata = REG_DW'(replaceCnt);
        REG_FAULT_ADDR: next_regRdata = REG_DW'(faultAddr);
        REG_REFILL_PTR: next_regRdata = refillPtr;
        REG_ADDR_MODE: next_regRdata = REG_DW'(wideMode);
        REG_FAULT_CAUSE: next_regRdata = REG_DW'(lastCause);
        default: next_regRdata = '0;
      endcase
    if (regWrite)
      case (regAddr)
        REG_ENTRY_KEY:
        begin
          next_keyVpn = key_of(regWdata[KEY_VPN_LSB +: VPN_W]);
          next_keyTag = regWdata[KEY_TAG_LSB +: TAG_MAX_W] & TAG_KEEP;
        end
        REG_DATA_EVEN: next_dataEven = regWdata[DATA_W-1:0];
        REG_DATA_ODD: next_dataOdd = VAR_PAGE ? regWdata[DATA_W-1:0] : '0;
        REG_PAGE_MASK: next_page_size_mask = VAR_PAGE ? regWdata[MASK_LSB +: MASK_W] : '0;
        REG_ENTRY_SELECT:
          // out-of-range slots are refused, the old selection stays
          if (regWdata[REG_DW-1:0] < REG_DW'(ENTRIES))
            next_entrySel = regWdata[IDX_W-1:0];
        REG_REFILL_PTR:
          next_refillPtr = {regWdata[REG_DW-1:REFILL_LOW_W], refillPtr[REFILL_LOW_W-1:0]};
        REG_ADDR_MODE: next_wideMode = regWdata[0];
        REG_COMMAND:
          case (regWdata[7:0])
            CMD_READ_INDEXED:
            begin
              next_keyVpn = entries[entrySel].virtual_page_number;
              next_keyTag = entries[entrySel].tag;
              next_page_size_mask = entries[entrySel].mask;
              next_dataEven = entries[entrySel].even;
              next_dataOdd = entries[entrySel].odd;
              next_dataEven[DATA_GLOBAL_BIT] = entries[entrySel].glob;
              next_dataOdd[DATA_GLOBAL_BIT] = VAR_PAGE & entries[entrySel].glob;
            end
            CMD_WRITE_INDEXED: entWrite = 1'b1;
            CMD_WRITE_RANDOM:
            begin
              entWrite = 1'b1;
              entIdx = replaceCnt;
            end
            default: entWrite = 1'b0;
          endcase
        default: next_entrySel = entrySel;
      endcase
    // a trap in the same cycle as a software write wins
    if (lookupReq.valid && lkCause != FLT_NONE)
    begin
      next_faultAddr = lookupReq.va;
      next_refillPtr[REFILL_LOW_W-1:0] =
        {lookupReq.va[REFILL_VA_MSB:REFILL_VA_LSB], 2'b00};
      next_keyVpn = key_of(lkVpn);
      next_lastCause = lkCause;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      keyVpn <= '0;
      keyTag <= '0;
      dataEven <= '0;
      dataOdd <= '0;
      page_size_mask <= '0;
      entrySel <= '0;
      replaceCnt <= LAST_IDX;
      faultAddr <= '0;
      refillPtr <= RST_REG;
      wideMode <= RST_WIDE_MODE;
      lastCause <= FLT_NONE;
      regRdata <= RST_REG;
      lookupResp <= '0;
    end
    else
    begin
      keyVpn <= next_keyVpn;
      keyTag <= next_keyTag;
      dataEven <= next_dataEven;
      dataOdd <= next_dataOdd;
      page_size_mask <= next_page_size_mask;
      entrySel <= next_entrySel;
      replaceCnt <= next_replaceCnt;
      faultAddr <= next_faultAddr;
      refillPtr <= next_refillPtr;
      wideMode <= next_wideMode;
      lastCause <= next_lastCause;
      regRdata <= next_regRdata;
      lookupResp <= next_resp;
    end
  end

  // entries come out of reset unusable so a stray zero key cannot translate
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      for (int i = 0; i < ENTRIES; i++)
      begin
        entries[i] <= '0;
        entries[i].even[DATA_VALID_BIT] <= !USABLE_VAL;
        entries[i].odd[DATA_VALID_BIT] <= !USABLE_VAL;
      end
    else if (entWrite)
      entries[entIdx] <= entNew;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_offset_passes: assert property (
    lookupReq.valid && lkHit |=> lookupResp.pa[PAGE_SHIFT-1:0] == $past(lookupReq.va[11:0]))
    else $error("page offset not passed through");
  a_miss_refill: assert property (
    lookupReq.valid && hitVec == '0 |=> lookupResp.fault && lookupResp.cause == FLT_REFILL)
    else $error("miss without refill trap");
  a_store_permit: assert property (
    lookupReq.valid && lookupReq.kind == ACC_STORE && lkHit
    && selData[DATA_VALID_BIT] == USABLE_VAL && !selData[DATA_WRITE_BIT]
    |=> lookupResp.cause == FLT_WRITE)
    else $error("store to protected page not trapped");
  a_fault_addr: assert property (
    lookupReq.valid && lkCause != FLT_NONE |=> faultAddr == $past(lookupReq.va)
    && lastCause == $past(lkCause))
    else $error("faulting address not captured");
  a_refill_low: assert property (
    lookupReq.valid && lkCause != FLT_NONE
    |=> refillPtr[REFILL_LOW_W-1:0] == {$past(lookupReq.va[31:13]), 2'b00})
    else $error("refill pointer low bits wrong");
  // sampled reset in the antecedent: the release edge still holds the counter at its reset value
  a_replace_step: assert property (
    rst_n && replaceCnt != '0 |=> replaceCnt == $past(replaceCnt) - 1'b1)
    else $error("replace counter did not step");
  a_replace_wrap: assert property (
    replaceCnt == '0 |=> replaceCnt == LAST_IDX)
    else $error("replace counter did not wrap");
  a_select_load: assert property (
    regWrite && regAddr == REG_ENTRY_SELECT && regWdata < REG_DW'(ENTRIES)
    |=> entrySel == $past(regWdata[IDX_W-1:0]))
    else $error("entry select not loaded");
  a_uncached_flag: assert property (
    lookupReq.valid && lkHit && (VAR_PAGE ? selAttr == ATTR_UNCACHED : selAttr[0])
    |=> lookupResp.uncached && lookupResp.policy == CP_UNCACHED)
    else $error("uncached page not flagged");
  a_pair_key: assert property (
    regWrite && regAddr == REG_ENTRY_KEY |=> !VAR_PAGE || keyVpn[0] == 1'b0)
    else $error("pair key keeps low page bit");

endmodule

//--- tlb_pipe_model.sv
// pipeline stand-in: issues fetch, load and store lookups two back to back.
// assumes the translation block answers exactly one cycle after each request.
`timescale 1ns/10ps
module tlb_pipe_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // lookup port
  output tlb_pkg::tlb_req_t lookupReq,
  input tlb_pkg::tlb_resp_t lookupResp
);
  import tlb_pkg::*;

  initial lookupReq = '0;

  // ****************************************
  // two requests on consecutive edges
  // ****************************************
  // idle address is the inverse of the last one so a stale value never matches
  task automatic burst(input tlb_acc_t k0, input logic [VA_W-1:0] v0, input tlb_acc_t k1,
    input logic [VA_W-1:0] v1, output tlb_resp_t r0, output tlb_resp_t r1);
    @(posedge clk_sys);
    lookupReq <= '{1'b1, k0, v0};
    @(posedge clk_sys);
    lookupReq <= '{1'b1, k1, v1};
    #1 r0 = lookupResp;
    @(posedge clk_sys);
    lookupReq <= '{1'b0, k1, ~v1};
    #1 r1 = lookupResp;
  endtask
endmodule

//--- tlb_address_translation_test.sv
// self-checking bench for the translation buffer, default variable-page build.
// assumes the pipeline model answers through its burst task.
`timescale 1ns/10ps
module tlb_address_translation_test;
  import tlb_pkg::*;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [REG_AW-1:0] regAddr = 8'h00;
  logic [REG_DW-1:0] regWdata = 64'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [REG_DW-1:0] regRdata;
  tlb_req_t lookupReq;
  tlb_resp_t lookupResp;
  tlb_resp_t r0;
  tlb_resp_t r1;
  int bad_count = 0;
  int checked = 0;

  always #5 clk_sys = ~clk_sys;

  tlb_address_translation u_tlb_address_translation (.clk_sys(clk_sys), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .lookupReq(lookupReq), .lookupResp(lookupResp));
  tlb_pipe_model u_tlb_pipe_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .lookupReq(lookupReq), .lookupResp(lookupResp));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [63:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask

  function automatic logic [63:0] key(input logic [39:0] va, input logic [7:0] tag);
    return {24'h0, va[39:13], 5'h0, tag};
  endfunction

  function automatic logic [63:0] dw(input logic [23:0] physical_frame_number, input logic [2:0] attr,
    input logic w, input logic v, input logic g);
    return {34'h0, physical_frame_number, attr, w, v, g};
  endfunction

  // distinct slots and keys, never two entries matching one key
  task automatic install(input logic [7:0] sel, input logic [7:0] cmd, input logic [63:0] k,
    input logic [63:0] ev, input logic [63:0] od, input logic [11:0] mask);
    wr(REG_ENTRY_SELECT, {56'h0, sel});
    wr(REG_ENTRY_KEY, k);
    wr(REG_DATA_EVEN, ev);
    wr(REG_DATA_ODD, od);
    wr(REG_PAGE_MASK, {39'h0, mask, 13'h0});
    wr(REG_COMMAND, {56'h0, cmd});
  endtask

  task automatic hitchk(input tlb_resp_t r, input logic [35:0] pa, input logic unc,
    input logic [2:0] pol);
    chk({r.valid, r.hit, r.fault, r.cause, r.pa, r.uncached, r.policy},
      {3'h6, 2'h0, pa, unc, pol});
  endtask

  task automatic faultchk(input tlb_resp_t r, input logic [1:0] cause);
    chk({r.valid, r.fault, r.cause}, {2'h3, cause});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_basic;
    install(8'h03, CMD_WRITE_INDEXED, key(40'h12000, 8'h05), dw(24'h100, 3'h3, 1'b1, 1'b0,
      1'b0), dw(24'h200, 3'h2, 1'b0, 1'b0, 1'b0), 12'h000);
    u_tlb_pipe_model.burst(ACC_LOAD, 40'h12345, ACC_LOAD, 40'h13abc, r0, r1);
    hitchk(r0, 36'h100345, 1'b0, 3'h3);
    hitchk(r1, 36'h200abc, 1'b1, 3'h2);
    u_tlb_pipe_model.burst(ACC_STORE, 40'h12345, ACC_FETCH, 40'h12ff0, r0, r1);
    hitchk(r0, 36'h100345, 1'b0, 3'h3);
    hitchk(r1, 36'h100ff0, 1'b0, 3'h3);
    u_tlb_pipe_model.burst(ACC_STORE, 40'h13abc, ACC_STORE, 40'h13abc, r0, r1);
    faultchk(r0, FLT_WRITE);
    rdchk(REG_FAULT_ADDR, 64'h13abc);
    rdchk(REG_FAULT_CAUSE, 64'h3);
    $display("basic translation done");
  endtask

  task automatic t_readback;
    wr(REG_ENTRY_SELECT, 64'h3);
    wr(REG_COMMAND, {56'h0, CMD_READ_INDEXED});
    rdchk(REG_ENTRY_KEY, key(40'h12000, 8'h05));
    rdchk(REG_DATA_EVEN, dw(24'h100, 3'h3, 1'b1, 1'b0, 1'b0));
    rdchk(REG_DATA_ODD, dw(24'h200, 3'h2, 1'b0, 1'b0, 1'b0));
    rdchk(8'h30, 64'h0);
    $display("entry readback done");
  endtask

  task automatic t_refill;
    wr(REG_REFILL_PTR, 64'habc0_0000_001f_ffff);
    wr(REG_ENTRY_KEY, key(40'h52000, 8'h06));
    u_tlb_pipe_model.burst(ACC_LOAD, 40'h12345, ACC_LOAD, 40'h12345, r0, r1);
    faultchk(r0, FLT_REFILL);
    chk({r0.hit, r0.pa}, 37'h0);
    rdchk(REG_FAULT_ADDR, 64'h12345);
    rdchk(REG_REFILL_PTR, 64'habc0_0000_0000_0024);
    rdchk(REG_ENTRY_KEY, key(40'h12000, 8'h06));
    $display("refill trap done");
  endtask

  task automatic t_global_invalid;
    install(8'h04, CMD_WRITE_INDEXED, key(40'h40000, 8'h05), dw(24'h300, 3'h0, 1'b1, 1'b0,
      1'b1), dw(24'h301, 3'h3, 1'b1, 1'b0, 1'b1), 12'h000);
    install(8'h05, CMD_WRITE_INDEXED, key(40'h80000, 8'h06), dw(24'h400, 3'h0, 1'b1, 1'b1,
      1'b0), dw(24'h401, 3'h1, 1'b1, 1'b0, 1'b0), 12'h000);
    u_tlb_pipe_model.burst(ACC_LOAD, 40'h40008, ACC_LOAD, 40'h41008, r0, r1);
    hitchk(r0, 36'h300008, 1'b0, 3'h0);
    hitchk(r1, 36'h301008, 1'b0, 3'h3);
    u_tlb_pipe_model.burst(ACC_LOAD, 40'h80010, ACC_FETCH, 40'h81010, r0, r1);
    faultchk(r0, FLT_INVALID);
    hitchk(r1, 36'h401010, 1'b0, 3'h1);
    $display("global and invalid done");
  endtask

  task automatic t_bigpage;
    install(8'h06, CMD_WRITE_INDEXED, key(40'h2123456, 8'h06), dw(24'h1000, 3'h3, 1'b1,
      1'b0, 1'b0), dw(24'h2000, 3'h3, 1'b1, 1'b0, 1'b0), 12'hfff);
    u_tlb_pipe_model.burst(ACC_LOAD, 40'h2123456, ACC_LOAD, 40'h3000010, r0, r1);
    hitchk(r0, 36'h1123456, 1'b0, 3'h3);
    hitchk(r1, 36'h2000010, 1'b0, 3'h3);
    $display("large page done");
  endtask

  task automatic t_random;
    install(8'h00, CMD_WRITE_RANDOM, key(40'hc0000, 8'h06), dw(24'h500, 3'h3, 1'b1, 1'b0,
      1'b0), dw(24'h501, 3'h3, 1'b1, 1'b0, 1'b0), 12'h000);
    u_tlb_pipe_model.burst(ACC_LOAD, 40'hc0123, ACC_LOAD, 40'hc1123, r0, r1);
    hitchk(r0, 36'h500123, 1'b0, 3'h3);
    hitchk(r1, 36'h501123, 1'b0, 3'h3);
    $display("random slot write done");
  endtask

  // upper address bits only take part in the key in 64-bit mode
  task automatic t_wide;
    wr(REG_ADDR_MODE, 64'h1);
    rdchk(REG_ADDR_MODE, 64'h1);
    @(posedge clk_sys);
    #1 chk(regRdata, 64'h0);
    install(8'h07, CMD_WRITE_INDEXED, key(40'h80_0001_2000, 8'h06), dw(24'h700, 3'h3, 1'b1,
      1'b0, 1'b0), dw(24'h701, 3'h3, 1'b1, 1'b0, 1'b0), 12'h000);
    u_tlb_pipe_model.burst(ACC_LOAD, 40'h80_0001_2345, ACC_LOAD, 40'h80_0001_3008, r0, r1);
    hitchk(r0, 36'h700345, 1'b0, 3'h3);
    hitchk(r1, 36'h701008, 1'b0, 3'h3);
    wr(REG_ADDR_MODE, 64'h0);
    u_tlb_pipe_model.burst(ACC_LOAD, 40'h80_0001_2345, ACC_LOAD, 40'h80_0001_2345, r0, r1);
    faultchk(r0, FLT_REFILL);
    $display("wide addressing done");
  endtask

  // ****************************************
  // run and verdict
  // ****************************************
  task automatic results;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #200000;
    bad_count++;
    results();
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(REG_FAULT_ADDR, 64'h0);
    t_basic();
    t_readback();
    t_refill();
    t_global_invalid();
    t_bigpage();
    t_random();
    t_wide();
    results();
  end
endmodule
